// ==== logic/lar_defs.vh ====
// Purpose: shared constants for the light converter register block
// Assumes: byte-wide register map on an I2C target, 125 MHz system clock
// Notes: definitions only
`ifndef LAR_DEFS_VH
`define LAR_DEFS_VH
// fixed 7-bit target address, not configurable
`define LAR_I2C_ADDR 7'h44
// register offsets
`define LAR_OFS_CMD1 8'h00
`define LAR_OFS_CFG 8'h01
`define LAR_OFS_RES_LO 8'h02
`define LAR_OFS_RES_HI 8'h03
`define LAR_OFS_LLIM_LO 8'h04
`define LAR_OFS_LLIM_HI 8'h05
`define LAR_OFS_HLIM_LO 8'h06
`define LAR_OFS_HLIM_HI 8'h07
// config register fields
`define LAR_CFG_RES_MSB 3
`define LAR_CFG_RES_LSB 2
`define LAR_CFG_RNG_MSB 1
`define LAR_CFG_RNG_LSB 0
`define LAR_CFG_USED_MASK 8'h0f
// reset values
`define LAR_CFG_RST 8'h00
`define LAR_RESULT_RST 16'h0000
`define LAR_LLIM_RST 8'h00
`define LAR_HLIM_RST 8'hff
// resolution codes
`define LAR_RES_16 2'b00
`define LAR_RES_12 2'b01
`define LAR_RES_8 2'b10
`define LAR_RES_4 2'b11
// oscillator timing
`define LAR_CLK_FREQ_KHZ 125000
`define LAR_OSC_FREQ_KHZ 725
`define LAR_OSC_DIV (`LAR_CLK_FREQ_KHZ / `LAR_OSC_FREQ_KHZ)
// persistence counts
`define LAR_PERSIST_1 5'd1
`define LAR_PERSIST_4 5'd4
`define LAR_PERSIST_8 5'd8
`define LAR_PERSIST_16 5'd16
`endif

// ==== logic/lar_integrator.v ====
// Purpose: integration timer and count accumulator for one conversion
// Assumes: light_pulse is a one-cycle pulse already on clk
// Notes: settings latched at the start of each integration
`timescale 1ns/1ps
`include "lar_defs.vh"
module lar_integrator #(
  parameter OSC_DIV = `LAR_OSC_DIV
)(
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire run,
  input wire [1:0] res_code,
  input wire [1:0] rng_code,
  input wire light_pulse,
  // results
  output reg done,
  output reg [15:0] result,
  output reg [1:0] active_rng
);
  reg [15:0] div_reg;
  reg [16:0] tick_reg;
  reg [15:0] acc_reg;
  reg [1:0] act_res_reg;
  reg busy_reg;
  reg [16:0] span;
  reg [15:0] cap;
  wire osc_tick;

  // internal oscillator period derived from clk
  assign osc_tick = (div_reg == OSC_DIV[15:0] - 16'h0001);

  // clock count and saturation cap per resolution
  always @*
  begin
    case (act_res_reg)
      `LAR_RES_16: span = 17'h10000;
      `LAR_RES_12: span = 17'h01000;
      `LAR_RES_8: span = 17'h00100;
      default: span = 17'h00010;
    endcase
    cap = span[15:0] - 16'h0001;
    if (act_res_reg == `LAR_RES_16)
      cap = 16'hffff;
  end

  // integration sequencer
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      div_reg <= 16'h0000;
      tick_reg <= 17'h00000;
      acc_reg <= 16'h0000;
      act_res_reg <= `LAR_RES_16;
      active_rng <= 2'b00;
      busy_reg <= 1'b0;
      done <= 1'b0;
      result <= `LAR_RESULT_RST;
    end
    else
    begin
      done <= 1'b0;
      div_reg <= osc_tick ? 16'h0000 : div_reg + 16'h0001;
      if (!busy_reg)
      begin
        if (run)
        begin
          // new settings take effect only here, never mid-integration
          act_res_reg <= res_code;
          active_rng <= rng_code;
          busy_reg <= 1'b1;
          tick_reg <= 17'h00000;
          acc_reg <= 16'h0000;
          div_reg <= 16'h0000;
        end
      end
      else
      begin
        if (light_pulse && acc_reg != cap)
          acc_reg <= acc_reg + 16'h0001;
        if (osc_tick)
        begin
          if (tick_reg == span - 17'h00001)
          begin
            // window closes after exactly 2^n oscillator periods
            result <= acc_reg & cap;
            done <= 1'b1;
            busy_reg <= 1'b0;
          end
          else
            tick_reg <= tick_reg + 17'h00001;
        end
      end
    end
  end
endmodule

// ==== logic/lar_top.v ====
// Purpose: I2C target with config, result and threshold registers of a light converter
// Assumes: host is an I2C controller; front end delivers charge-balance pulses
// Notes: command register 00 lives elsewhere; its mode, clear and persistence are ports
`timescale 1ns/1ps
`include "lar_defs.vh"
// How it works
// - resolution code picks 16, 12, 8 or 4 bits and matching clock count.
// - integration length follows the chosen clock count.
// - range code picks range 1 to 4, full scale 1k to 64k lux.
// - result low byte at 02, high at 03, read only.
// - result right aligned at bit 0, top bit follows resolution.
// - both result bytes overwritten at end of every conversion.
// - low threshold at 04/05, reset 00.
// - high threshold at 06/07, reset ff.
// - each integration lasts exactly 2^n oscillator periods.
// - conversion timing from internal oscillator of nominal 725 kHz.
// - unsigned result, full scale 2^n counts, proportional to light.
// - responds on fixed 7-bit I2C address 1000100.
// - flag and pin raised after m consecutive out-of-window results.
// - upper config bits read zero; settings hold until overwritten.
module lar_top #(
  parameter OSC_DIV = `LAR_OSC_DIV
)(
  // clock and reset
  input wire clk,
  input wire rstn,
  // i2c pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // front end
  input wire light_pulse_in,
  output reg [1:0] scale_select,
  // command register 00 side
  input wire conv_run,
  input wire [1:0] persistence_count_select,
  input wire flag_clear,
  output reg int_flag,
  output reg int_out,
  output reg int_oe
);
  localparam S_IDLE = 4'd0;
  localparam S_ADDR = 4'd1;
  localparam S_AACK = 4'd2;
  localparam S_PTR = 4'd3;
  localparam S_PACK = 4'd4;
  localparam S_WR = 4'd5;
  localparam S_WACK = 4'd6;
  localparam S_RD = 4'd7;
  localparam S_RACK = 4'd8;

  reg scl_m, scl_s, scl_d;
  reg sda_m, sda_s, sda_d;
  reg lp_m, lp_s, lp_d;
  reg [3:0] state_reg;
  reg [3:0] bit_reg;
  reg [7:0] rx_reg;
  reg [7:0] tx_reg;
  reg [7:0] ptr_reg;
  reg rw_reg;
  reg nack_reg;
  reg [7:0] cfg_reg;
  reg [15:0] llim_reg;
  reg [15:0] hlim_reg;
  reg [4:0] pers_reg;
  reg [4:0] need;
  reg [7:0] rd_mux;
  reg conv_done_q;
  wire scl_rise, scl_fall, start_c, stop_c;
  wire conv_done;
  wire [15:0] conv_result;
  wire [1:0] conv_rng;
  wire out_of_window;

  // two-stage synchronisers on the pins
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      {scl_m, scl_s, scl_d} <= 3'b111;
      {sda_m, sda_s, sda_d} <= 3'b111;
      {lp_m, lp_s, lp_d} <= 3'b000;
    end
    else
    begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      lp_m <= light_pulse_in;
      lp_s <= lp_m;
      lp_d <= lp_s;
    end
  end

  // bus events from synchronised levels
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  // conversion engine, runs off the internal oscillator tick
  lar_integrator #(
    .OSC_DIV(OSC_DIV)
  ) u_integ (
    .clk(clk),
    .rstn(rstn),
    .run(conv_run),
    .res_code(cfg_reg[`LAR_CFG_RES_MSB:`LAR_CFG_RES_LSB]),
    .rng_code(cfg_reg[`LAR_CFG_RNG_MSB:`LAR_CFG_RNG_LSB]),
    .light_pulse(lp_s & ~lp_d),
    .done(conv_done),
    .result(conv_result),
    .active_rng(conv_rng)
  );

  // read data selection; unmapped offsets read zero
  always @*
  begin
    case (ptr_reg)
      `LAR_OFS_CMD1: rd_mux = 8'h00;
      `LAR_OFS_CFG: rd_mux = cfg_reg & `LAR_CFG_USED_MASK;
      `LAR_OFS_RES_LO: rd_mux = conv_result[7:0];
      `LAR_OFS_RES_HI: rd_mux = conv_result[15:8];
      `LAR_OFS_LLIM_LO: rd_mux = llim_reg[7:0];
      `LAR_OFS_LLIM_HI: rd_mux = llim_reg[15:8];
      `LAR_OFS_HLIM_LO: rd_mux = hlim_reg[7:0];
      `LAR_OFS_HLIM_HI: rd_mux = hlim_reg[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  // i2c target; sda changes only after scl falls to keep data stable while high
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= S_IDLE;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      cfg_reg <= `LAR_CFG_RST;
      llim_reg <= {`LAR_LLIM_RST, `LAR_LLIM_RST};
      hlim_reg <= {`LAR_HLIM_RST, `LAR_HLIM_RST};
    end
    else if (start_c)
    begin
      state_reg <= S_ADDR;
      bit_reg <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (stop_c)
    begin
      state_reg <= S_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      if (scl_rise)
      begin
        rx_reg <= {rx_reg[6:0], sda_s};
        bit_reg <= bit_reg + 4'h1;
        if (state_reg == S_RACK)
          nack_reg <= sda_s;
      end
      if (scl_fall)
      begin
        case (state_reg)
          S_ADDR:
            if (bit_reg == 4'h8)
            begin
              if (rx_reg[7:1] == `LAR_I2C_ADDR)
              begin
                rw_reg <= rx_reg[0];
                sda_oe <= 1'b1;
                state_reg <= S_AACK;
              end
              else
                state_reg <= S_IDLE;
            end
          S_AACK:
          begin
            bit_reg <= 4'h0;
            if (rw_reg)
            begin
              tx_reg <= rd_mux;
              sda_oe <= ~rd_mux[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= S_RD;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_reg <= S_PTR;
            end
          end
          S_PTR:
            if (bit_reg == 4'h8)
            begin
              ptr_reg <= rx_reg;
              sda_oe <= 1'b1;
              state_reg <= S_PACK;
            end
          S_WR:
            if (bit_reg == 4'h8)
            begin
              // result and reserved offsets swallow writes unchanged
              case (ptr_reg)
                `LAR_OFS_CFG: cfg_reg <= rx_reg & `LAR_CFG_USED_MASK;
                `LAR_OFS_LLIM_LO: llim_reg[7:0] <= rx_reg;
                `LAR_OFS_LLIM_HI: llim_reg[15:8] <= rx_reg;
                `LAR_OFS_HLIM_LO: hlim_reg[7:0] <= rx_reg;
                `LAR_OFS_HLIM_HI: hlim_reg[15:8] <= rx_reg;
                default: cfg_reg <= cfg_reg;
              endcase
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe <= 1'b1;
              state_reg <= S_WACK;
            end
          S_PACK, S_WACK:
          begin
            sda_oe <= 1'b0;
            bit_reg <= 4'h0;
            state_reg <= S_WR;
          end
          S_RD:
            if (bit_reg == 4'h8)
            begin
              sda_oe <= 1'b0;
              state_reg <= S_RACK;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe <= ~tx_reg[6];
            end
          S_RACK:
          begin
            bit_reg <= 4'h0;
            if (nack_reg)
            begin
              sda_oe <= 1'b0;
              state_reg <= S_IDLE;
            end
            else
            begin
              tx_reg <= rd_mux;
              sda_oe <= ~rd_mux[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= S_RD;
            end
          end
          S_IDLE: sda_oe <= 1'b0;
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // persistence target m from the two select bits
  always @*
  begin
    case (persistence_count_select)
      2'b00: need = `LAR_PERSIST_1;
      2'b01: need = `LAR_PERSIST_4;
      2'b10: need = `LAR_PERSIST_8;
      default: need = `LAR_PERSIST_16;
    endcase
  end

  assign out_of_window = (conv_result < llim_reg) || (conv_result > hlim_reg);

  // out-of-window run counter; a set in the clear cycle wins
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      pers_reg <= 5'd0;
      int_flag <= 1'b0;
      int_out <= 1'b0;
      int_oe <= 1'b0;
      scale_select <= 2'b00;
    end
    else
    begin
      scale_select <= conv_rng;
      if (conv_done_q)
      begin
        if (out_of_window)
        begin
          // no carry out of 5 bits, so a saturated count still re-asserts
          if (pers_reg >= need - 5'd1)
          begin
            int_flag <= 1'b1;
            int_oe <= 1'b1;
          end
          else if (flag_clear)
          begin
            int_flag <= 1'b0;
            int_oe <= 1'b0;
          end
          if (pers_reg != 5'd31)
            pers_reg <= pers_reg + 5'd1;
        end
        else
        begin
          pers_reg <= 5'd0;
          if (flag_clear)
          begin
            int_flag <= 1'b0;
            int_oe <= 1'b0;
          end
        end
      end
      else if (flag_clear)
      begin
        int_flag <= 1'b0;
        int_oe <= 1'b0;
      end
    end
  end

  // compare one cycle after the result register has settled
  always @(posedge clk)
  begin
    if (!rstn)
      conv_done_q <= 1'b0;
    else
      conv_done_q <= conv_done;
  end
endmodule

// ==== verification/lar_chk.sv ====
// Purpose: port checker for lar_top
// Assumes: one clk domain, rstn synchronous active low
// Notes: both pins are open drain
`timescale 1ns/1ps
module lar_chk (
  // clock and reset
  input wire clk,
  input wire rstn,
  // inputs watched
  input wire scl_in,
  input wire conv_run,
  input wire flag_clear,
  // outputs
  input wire sda_out,
  input wire sda_oe,
  input wire [1:0] scale_select,
  input wire int_flag,
  input wire int_out,
  input wire int_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // open drain: the driven value is never high
  sda_drain_a: assert property (!sda_out) else $error("sda value high");
  int_drain_a: assert property (!int_out) else $error("int value high");
  int_pin_a: assert property (int_oe == int_flag) else $error("pin off flag");
  // state right after reset
  reset_idle_a: assert property ($rose(rstn) |-> !int_flag && scale_select == 2'b00)
    else $error("bad reset state");
  sync_quiet_a: assert property ($rose(rstn) |-> !sda_oe [*4])
    else $error("sda pulled during sync fill");
  // data only moves while the host holds scl low
  sda_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved while scl high");
  // range is taken only when a run is requested; it shows two clk after that edge
  scale_latch_a: assert property ($changed(scale_select) |-> $past(conv_run, 2))
    else $error("range moved without run");
  flag_hold_a: assert property ($fell(int_flag) |-> $past(flag_clear))
    else $error("flag dropped uncleared");
  cover property ($rose(int_flag));
  cover property ($rose(sda_oe));
  cover property ($changed(scale_select));
endmodule

// ==== verification/lar_host.sv ====
// Purpose: I2C controller model for the light converter
// Assumes: SDA pull-up; SCL low and high 8 clk each
// Notes: every change lands on a falling clk edge
`timescale 1ns/1ps
module lar_host (
  // clock
  input wire clk,
  // bus
  input wire dev_pull,
  output logic scl,
  output wire sda
);
  logic pull = 1'b0;
  initial scl = 1'b1;
  // pull-up wins unless a party pulls low
  assign sda = ~(pull | dev_pull);
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // p=0 start or repeated start, p=1 stop; sda moves with scl high
  task automatic cond(input logic p);
    wt(4);
    pull = p;
    wt(4);
    scl = 1'b1;
    wt(8);
    pull = ~p;
    wt(8);
    scl = p;
  endtask
  // one bit, set in mid low, sampled in mid high
  task automatic bit_io(input logic b, output logic r);
    wt(4);
    pull = ~b;
    wt(4);
    scl = 1'b1;
    wt(4);
    r = sda;
    wt(4);
    scl = 1'b0;
  endtask
  // byte msb first, then the ninth bit; last=1 releases it
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, r);
    ack = ~r;
  endtask
endmodule

// ==== verification/light_adc_config_result_regs_tb.sv ====
// Purpose: self-checking bench for lar_top
// Assumes: OSC_DIV of 1, so one tick per clk
// Notes: reads note expected bytes in a queue
`timescale 1ns/1ps
module light_adc_config_result_regs_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic light = 1'b0;
  logic run = 1'b0;
  logic [1:0] pers = 2'b00;
  logic clr = 1'b0;
  wire scl;
  wire sda;
  wire sda_oe;
  wire [1:0] scale_select;
  wire int_flag;
  wire int_oe;
  wire sda_val;
  wire int_val;
  int num_errors = 0;
  int checks_done = 0;
  int m;
  logic [31:0] seed = 32'he7a1c311;
  logic [31:0] lim;
  logic [15:0] p;
  logic [7:0] cfg[4];
  logic [7:0] obs;
  logic [7:0] q;
  logic [7:0] exp_q[$];
  logic a;
  event got;
  always #4 clk = ~clk;
  lar_top #(.OSC_DIV(1)) dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_val), .sda_oe(sda_oe), .light_pulse_in(light), .scale_select(scale_select),
    .conv_run(run), .persistence_count_select(pers), .flag_clear(clr),
    .int_flag(int_flag), .int_out(int_val), .int_oe(int_oe));
  lar_host host (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic ck(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // start, address+W, pointer
  task automatic head(input logic [7:0] ofs);
    host.cond(1'b0);
    host.xfer(8'h88, 1'b1, q, a);
    ck(a, "address not acked");
    host.xfer(ofs, 1'b1, q, a);
    ck(a, "pointer not acked");
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    head(ofs);
    host.xfer(d, 1'b1, q, a);
    ck(a, "data not acked");
    host.cond(1'b1);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
    exp_q.push_back(e);
    head(ofs);
    host.cond(1'b0);
    host.xfer(8'h89, 1'b1, q, a);
    host.xfer(8'hff, 1'b1, obs, a);
    ->got;
    host.cond(1'b1);
  endtask
  task automatic pulse();
    light = 1'b1;
    wt(2);
    light = 1'b0;
    wt(2);
  endtask
  // compare each byte read with the oldest note
  always @(got) ck(obs === exp_q.pop_front(), "read data");
  // main sequence
  initial
  begin
    wt(5);
    rstn = 1'b1;
    wt(4);
    for (int i = 1; i < 8; i++) rd(i[7:0], i > 5 ? 8'hff : 8'h00);
    host.cond(1'b0);
    host.xfer(8'h8c, 1'b1, q, a);
    ck(!a, "foreign address acked");
    host.cond(1'b1);
    wr(8'h01, 8'hf7);
    rd(8'h01, 8'h07);
    lim = lfsr(seed);
    head(8'h04);
    for (int i = 0; i < 4; i++) host.xfer(lim[8*i +: 8], 1'b1, q, a);
    host.cond(1'b1);
    for (int i = 0; i < 4; i++) rd(8'h04 + i[7:0], lim[8*i +: 8]);
    // every resolution code once, random range; no ripple on the light
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      cfg[i] = {4'h0, i[1:0], seed[1:0]};
    end
    for (int i = 0; i < 4; i++)
    begin
      if (i != 1) wr(8'h01, cfg[i]);
      run = 1'b1;
      wt(1);
      run = 1'b0;
      wt(2);
      ck(scale_select === cfg[i][1:0], "range");
      seed = lfsr(seed);
      p = i < 2 ? 16'd256 + seed[5:0] : (i == 2 ? 16'd1 + seed[4:0] : 16'd2);
      repeat (p) pulse();
      if (i == 0)
      begin
        rd(8'h03, 8'h00);
        wr(8'h01, cfg[1]);
        ck(scale_select === cfg[0][1:0], "range changed mid run");
      end
      wt((1 << (16 - 4 * i)) + 20);
      wr(8'h02, ~p[7:0]);
      rd(8'h02, p[7:0]);
      rd(8'h03, p[15:8]);
      ck(int_flag === (p < lim[15:0] || p > lim[31:16]), "flag");
      clr = 1'b1;
      wt(2);
      clr = 1'b0;
    end
    // persistence codes; result 0 lies below a low limit of 1
    for (int c = 0; c < 4; c++)
    begin
      rstn = 1'b0;
      wt(5);
      rstn = 1'b1;
      wt(4);
      wr(8'h01, 8'h0c);
      wr(8'h04, 8'h01);
      pers = c[1:0];
      m = c == 0 ? 1 : 4 << (c - 1);
      run = 1'b1;
      // each conversion is 16 ticks plus one idle clk; flag shows 2 clk after the m-th
      wt(17 * m - 4);
      ck(int_flag === 1'b0, "flag too early");
      wt(m + 12);
      ck(int_oe === 1'b1, "flag too late");
      run = 1'b0;
    end
    wt(40);
    clr = 1'b1;
    wt(2);
    ck(int_flag === 1'b0, "flag not cleared");
    clr = 1'b0;
    ck(sda_val === 1'b0 && int_val === 1'b0, "open drain value high");
    test_done();
  end
  // watchdog; a clean run needs about 96k clk, most of it the 16-bit window
  initial
  begin
    wt(105000);
    num_errors++;
    test_done();
  end
endmodule
bind lar_top lar_chk chk (.clk(clk), .rstn(rstn), .scl_in(scl_in), .conv_run(conv_run),
  .flag_clear(flag_clear), .sda_out(sda_out), .sda_oe(sda_oe),
  .scale_select(scale_select), .int_flag(int_flag), .int_out(int_out), .int_oe(int_oe));
